//--- hw/adcsf_pkg.sv
// package for the converter status-flag block: register map, fields, types
package adcsf_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int RES_W = 10;
   localparam int NUM_CH = 8;
   localparam int CH_W = 3;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_CHEN = 8'h10;
   localparam logic [7:0] OFF_CHDIS = 8'h14;
   localparam logic [7:0] OFF_CHSR = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   localparam logic [7:0] OFF_LAST = 8'h20;
   localparam logic [7:0] OFF_IRQ_ST = 8'h24;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
   localparam logic [7:0] OFF_CHDATA0 = 8'h30;
   // field positions
   localparam int CTRL_START_BIT = 1;
   localparam int MODE_SLEEP_BIT = 5;
   localparam int ST_OVR_LSB = 8;
   localparam int ST_READY_BIT = 16;
   localparam int ST_GOVR_BIT = 17;
   localparam int LAST_CH_LSB = 12;
   // interrupt status bits
   localparam int IRQ_EOC_BIT = 0;
   localparam int IRQ_READY_BIT = 1;
   localparam int IRQ_GOVR_BIT = 2;
   localparam int IRQ_OVR_BIT = 3;
   localparam int IRQ_W = 4;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
   localparam logic [NUM_CH-1:0] CHEN_RESET = 8'h00;

   // one end of conversion from the analog core
   typedef struct packed {
      logic valid;
      logic [CH_W-1:0] chan;
      logic [RES_W-1:0] data;
   } adcsf_eoc_type;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } adcsf_bus_type;
endpackage

//--- hw/adcsf_top.sv
// status flags, data registers and sleep hand-off of the converter controller
// Function
// - only a last-data read clears data-ready; channel data reads leave it alone
// - last-data read with end of conversion sets data-ready only if result stored
// - channel read never blocks data-ready set by another channel's conversion
// - disable on one channel still stores and flags another channel's result
// - status read clears general overrun unless a new overrun arrives together
// - stored end of conversion with data-ready set raises general overrun, read or not
// - channel read together with another channel's end still detects general overrun
// - channel disable together with end still raises general and channel overrun
// - conversion-done cleared by its channel data read or last-data read
// - status read clears channel overrun unless a same-channel overrun arrives together
// - a channel disabled mid-conversion never raises its conversion-done
// - channel data read clears only that channel's conversion-done
// - new sleep setting applies at end of conversion; software writes sleep then start
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module adcsf_top
#(
   parameter int NCH = adcsf_pkg::NUM_CH
)
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire adcsf_pkg::adcsf_bus_type bus_i,
   output logic [adcsf_pkg::DATA_W-1:0] rdata_o,
   input wire adcsf_pkg::adcsf_eoc_type eoc_i,
   input wire logic [adcsf_pkg::CH_W-1:0] conv_chan_i,
   input wire logic conv_busy_i,
   output logic start_o,
   output logic [NCH-1:0] chan_en_o,
   output logic sleep_o,
   output logic irq_o
);
   import adcsf_pkg::*;

   // elaboration checks: the status word and the channel index only have room
   // for the package's channel count, and the reset words are that wide too
   generate
      if (NCH != NUM_CH)
      begin : g_bad_nch
         $error("adcsf_top: NCH must equal the package channel count");
      end
      if (NCH > (1 << CH_W))
      begin : g_bad_chw
         $error("adcsf_top: channel index too narrow for NCH");
      end
      if (ST_OVR_LSB < NCH || ST_OVR_LSB + NCH > ST_READY_BIT)
      begin : g_bad_fields
         $error("adcsf_top: status fields overlap for NCH channels");
      end
      if (LAST_CH_LSB < RES_W || RES_W > DATA_W)
      begin : g_bad_last
         $error("adcsf_top: result and channel fields overlap in the last data word");
      end
      if (int'(OFF_CHDATA0) + 4 * NCH > (1 << ADDR_W))
      begin : g_bad_map
         $error("adcsf_top: channel data window runs past the address space");
      end
   endgenerate

   logic [RES_W-1:0] ch_data_reg [NCH];
   logic [RES_W-1:0] last_data_reg;
   logic [CH_W-1:0] last_chan_reg;
   logic [NCH-1:0] chan_en_reg;
   logic [NCH-1:0] conv_done_reg;
   logic [NCH-1:0] chan_ovr_reg;
   logic [NCH-1:0] killed_reg;
   logic data_ready_reg;
   logic gen_ovr_reg;
   logic sleep_setting_reg;
   logic sleep_reg;
   logic start_reg;
   logic [IRQ_W-1:0] irq_st_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [DATA_W-1:0] rdata_reg;

   // decoded accesses, all one-cycle strobes; the bus never raises two at once,
   // so no priority between them is needed
   logic wr_ctrl, wr_mode, wr_chen, wr_chdis, wr_irq_st, wr_irq_mask;
   logic rd_status, rd_last;
   logic [NCH-1:0] rd_ch;
   logic [NCH-1:0] eoc_hit;
   logic eoc_store;
   logic [ADDR_W-1:0] ch_off;

   assign wr_ctrl = bus_i.wr && (bus_i.addr == OFF_CTRL);
   assign wr_mode = bus_i.wr && (bus_i.addr == OFF_MODE);
   assign wr_chen = bus_i.wr && (bus_i.addr == OFF_CHEN);
   assign wr_chdis = bus_i.wr && (bus_i.addr == OFF_CHDIS);
   assign wr_irq_st = bus_i.wr && (bus_i.addr == OFF_IRQ_ST);
   assign wr_irq_mask = bus_i.wr && (bus_i.addr == OFF_IRQ_MASK);
   assign rd_status = bus_i.rd && (bus_i.addr == OFF_STATUS);
   assign rd_last = bus_i.rd && (bus_i.addr == OFF_LAST);
   assign ch_off = bus_i.addr - OFF_CHDATA0;

   // result is kept only for a channel enabled now and not disabled mid-conversion;
   // the enable seen before the edge decides, so a disable written together with
   // another channel's end cannot drop that other result
   assign eoc_store = eoc_i.valid && chan_en_reg[eoc_i.chan]
                      && !killed_reg[eoc_i.chan];

   // per-channel read decode and end-of-conversion hit, indexed strictly by channel;
   // both vectors are one-hot, so a read of one channel never reaches another
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         assign rd_ch[g] = bus_i.rd && (ch_off == ADDR_W'(4 * g));
         assign eoc_hit[g] = eoc_store && (eoc_i.chan == CH_W'(g));
      end
   endgenerate

   // channel enable; a disable never touches another channel's store path
   // set and clear cannot meet because the bus strobes one register per cycle
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         chan_en_reg <= CHEN_RESET;
      end
      else
      begin
         chan_en_reg <= (chan_en_reg | (wr_chen ? bus_i.wdata[NCH-1:0] : '0))
                        & ~(wr_chdis ? bus_i.wdata[NCH-1:0] : '0);
      end
   end

   // remember channels disabled while their conversion is running; the mark stays
   // until that channel's own end pulse, so a re-enable in between cannot revive
   // the stale result
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         killed_reg <= '0;
      end
      else
      begin
         for (int i = 0; i < NCH; i++)
         begin
            if (eoc_i.valid && eoc_i.chan == CH_W'(i))
            begin
               killed_reg[i] <= 1'b0;
            end
            else if (wr_chdis && bus_i.wdata[i] && conv_busy_i
                     && conv_chan_i == CH_W'(i))
            begin
               killed_reg[i] <= 1'b1;
            end
         end
      end
   end

   // data registers
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            ch_data_reg[i] <= '0;
         end
         last_data_reg <= '0;
         last_chan_reg <= '0;
      end
      else if (eoc_store)
      begin
         ch_data_reg[eoc_i.chan] <= eoc_i.data;
         last_data_reg <= eoc_i.data;
         last_chan_reg <= eoc_i.chan;
      end
   end

   // conversion-done and channel overrun; set wins over clear
   // the set branch comes first so a read that meets an end never loses the new
   // result; each done bit clears only on its own read strobe or a last-data read, each overrun bit on a status read
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         conv_done_reg <= '0;
         chan_ovr_reg <= '0;
      end
      else
      begin
         for (int i = 0; i < NCH; i++)
         begin
            if (eoc_hit[i])
            begin
               conv_done_reg[i] <= 1'b1;
            end
            else if (rd_ch[i] || rd_last)
            begin
               conv_done_reg[i] <= 1'b0;
            end
            if (eoc_hit[i] && conv_done_reg[i])
            begin
               chan_ovr_reg[i] <= 1'b1;
            end
            else if (rd_status)
            begin
               chan_ovr_reg[i] <= 1'b0;
            end
         end
      end
   end

   // data-ready and general overrun; only stored results count
   // overrun is judged on the ready level before the edge: a status read meeting a
   // plain end still clears it, one meeting a new overrun does not
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         data_ready_reg <= 1'b0;
         gen_ovr_reg <= 1'b0;
      end
      else
      begin
         if (eoc_store)
         begin
            data_ready_reg <= 1'b1;
         end
         else if (rd_last)
         begin
            data_ready_reg <= 1'b0;
         end
         if (eoc_store && data_ready_reg)
         begin
            gen_ovr_reg <= 1'b1;
         end
         else if (rd_status)
         begin
            gen_ovr_reg <= 1'b0;
         end
      end
   end

   // sleep setting is held and handed to the core only at an end of conversion
   // limitation: a setting written while idle waits for the next end pulse, so
   // software writes it before a start to make it take hold promptly
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         sleep_setting_reg <= 1'b0;
         sleep_reg <= 1'b0;
         start_reg <= 1'b0;
      end
      else
      begin
         if (wr_mode)
         begin
            sleep_setting_reg <= bus_i.wdata[MODE_SLEEP_BIT];
         end
         if (eoc_i.valid)
         begin
            sleep_reg <= sleep_setting_reg;
         end
         start_reg <= wr_ctrl && bus_i.wdata[CTRL_START_BIT];
      end
   end

   // sticky interrupt status, write one to clear, event wins over clear
   // the event is or-ed in after the clear, so a clear that meets it keeps the bit
   logic [IRQ_W-1:0] irq_ev;
   assign irq_ev[IRQ_EOC_BIT] = eoc_store;
   assign irq_ev[IRQ_READY_BIT] = eoc_store && !data_ready_reg;
   assign irq_ev[IRQ_GOVR_BIT] = eoc_store && data_ready_reg;
   assign irq_ev[IRQ_OVR_BIT] = |(eoc_hit & conv_done_reg);

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         irq_st_reg <= IRQ_RESET;
         irq_mask_reg <= IRQ_RESET;
      end
      else
      begin
         irq_st_reg <= (irq_st_reg & ~(wr_irq_st ? bus_i.wdata[IRQ_W-1:0] : '0)) | irq_ev;
         if (wr_irq_mask)
         begin
            irq_mask_reg <= bus_i.wdata[IRQ_W-1:0];
         end
      end
   end

   // read data one cycle after the strobe; unmapped reads return zero
   // write-only registers read as zero too; clears caused by a read show up
   // only from the following read on
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdata_reg <= '0;
      end
      else
      begin
         rdata_reg <= '0;
         if (bus_i.rd)
         begin
            case (bus_i.addr)
               OFF_MODE: rdata_reg[MODE_SLEEP_BIT] <= sleep_setting_reg;
               OFF_CHSR: rdata_reg[NCH-1:0] <= chan_en_reg;
               OFF_STATUS:
               begin
                  rdata_reg[NCH-1:0] <= conv_done_reg;
                  rdata_reg[ST_OVR_LSB +: NCH] <= chan_ovr_reg;
                  rdata_reg[ST_READY_BIT] <= data_ready_reg;
                  rdata_reg[ST_GOVR_BIT] <= gen_ovr_reg;
               end
               OFF_LAST:
               begin
                  rdata_reg[RES_W-1:0] <= last_data_reg;
                  rdata_reg[LAST_CH_LSB +: CH_W] <= last_chan_reg;
               end
               OFF_IRQ_ST: rdata_reg[IRQ_W-1:0] <= irq_st_reg;
               OFF_IRQ_MASK: rdata_reg[IRQ_W-1:0] <= irq_mask_reg;
               default:
               begin
                  for (int i = 0; i < NCH; i++)
                  begin
                     if (rd_ch[i])
                     begin
                        rdata_reg[RES_W-1:0] <= ch_data_reg[i];
                     end
                  end
               end
            endcase
         end
      end
   end

   // data and control outputs come straight from registers
   assign rdata_o = rdata_reg;
   assign chan_en_o = chan_en_reg;
   assign sleep_o = sleep_reg;
   assign start_o = start_reg;
   // level interrupt while any unmasked sticky bit stands
   assign irq_o = |(irq_st_reg & irq_mask_reg);
endmodule

//--- tb/adcsf_chk.sv
// port-level assertions for the converter status-flag block
`timescale 1ns/1ps
module adcsf_chk
#(
   parameter int NCH = 8
)
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire adcsf_pkg::adcsf_bus_type bus_i,
   input wire logic [adcsf_pkg::DATA_W-1:0] rdata_o,
   input wire adcsf_pkg::adcsf_eoc_type eoc_i,
   input wire logic [adcsf_pkg::CH_W-1:0] conv_chan_i,
   input wire logic conv_busy_i,
   input wire logic start_o,
   input wire logic [NCH-1:0] chan_en_o,
   input wire logic sleep_o,
   input wire logic irq_o
);
   import adcsf_pkg::*;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   logic st_req;
   logic [NCH-1:0] wd;
   // start request and the enable bits of the write word
   assign st_req = bus_i.wr && bus_i.addr == OFF_CTRL && bus_i.wdata[CTRL_START_BIT];
   assign wd = bus_i.wdata[NCH-1:0];
   chk_start_pulse: assert property (st_req |=> start_o)
      else $error("start pulse missing");
   chk_start_cause: assert property (start_o |-> $past(st_req))
      else $error("start pulse without request");
   chk_rdata_idle: assert property (!bus_i.rd |=> rdata_o == '0)
      else $error("read data outside answer cycle");
   chk_sleep_hold: assert property (!eoc_i.valid |=> $stable(sleep_o))
      else $error("sleep level moved without end of conversion");
   chk_en_set: assert property (bus_i.wr && bus_i.addr == OFF_CHEN |=>
      chan_en_o == ($past(chan_en_o) | $past(wd)))
      else $error("channel enable set wrong");
   chk_en_clear: assert property (bus_i.wr && bus_i.addr == OFF_CHDIS |=>
      chan_en_o == ($past(chan_en_o) & ~$past(wd)))
      else $error("channel disable wrong");
   chk_chsr_read: assert property (bus_i.rd && bus_i.addr == OFF_CHSR |=>
      rdata_o[NCH-1:0] == $past(chan_en_o))
      else $error("enable status read wrong");
   chk_irq_masked: assert property (bus_i.wr && bus_i.addr == OFF_IRQ_MASK &&
      bus_i.wdata[IRQ_W-1:0] == '0 |=> !irq_o)
      else $error("interrupt high with all masked");
   cov_start: cover property (start_o);
   cov_eoc_read: cover property (eoc_i.valid && bus_i.rd);
   cov_irq: cover property (irq_o);
endmodule

bind adcsf_top adcsf_chk #(.NCH(NCH)) u_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
   .bus_i(bus_i), .rdata_o(rdata_o), .eoc_i(eoc_i), .conv_chan_i(conv_chan_i),
   .conv_busy_i(conv_busy_i), .start_o(start_o), .chan_en_o(chan_en_o), .sleep_o(sleep_o),
   .irq_o(irq_o));

//--- tb/adcsf_core_model.sv
// analog core stand-in: fixed-latency conversion after each start pulse
`timescale 1ns/1ps
module adcsf_core_model
#(
   parameter int LAT = 3
)
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic start_i,
   input wire logic [adcsf_pkg::CH_W-1:0] ch_i,
   input wire logic [adcsf_pkg::RES_W-1:0] d_i,
   output adcsf_pkg::adcsf_eoc_type eoc_o,
   output logic [adcsf_pkg::CH_W-1:0] chan_o,
   output logic busy_o
);
   import adcsf_pkg::*;
   logic [3:0] cnt_reg;
   logic [RES_W-1:0] d_reg;
   // channel and result latched at start, end pulse LAT cycles later
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_reg <= 4'h0;
         chan_o <= '0;
         d_reg <= '0;
      end
      else if (start_i)
      begin
         cnt_reg <= 4'(LAT);
         chan_o <= ch_i;
         d_reg <= d_i;
      end
      else if (cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
   end
   assign busy_o = (cnt_reg != 4'h0);
   assign eoc_o.valid = (cnt_reg == 4'h1);
   assign eoc_o.chan = chan_o;
   // data lines show the inverse outside the pulse so stale values never match
   assign eoc_o.data = eoc_o.valid ? d_reg : ~d_reg;
endmodule

//--- tb/adcsf_top_tb.sv
// self-checking bench for the converter status-flag block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module adcsf_top_tb;
   import adcsf_pkg::*;
   localparam int LAT = 3;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   adcsf_bus_type bus_i = '0;
   adcsf_eoc_type eoc_i;
   logic [DATA_W-1:0] rdata_o, eq[$], mq[$];
   logic [CH_W-1:0] conv_chan_i, cch = '0;
   logic [RES_W-1:0] cd = '0, d;
   logic [NUM_CH-1:0] chan_en_o;
   logic conv_busy_i, start_o, sleep_o, irq_o, rd_d = 1'b0;
   int bad_count = 0, cmp_count = 0, seed = 32'h977D5153;
   adcsf_top dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .eoc_i(eoc_i), .conv_chan_i(conv_chan_i), .conv_busy_i(conv_busy_i),
      .start_o(start_o), .chan_en_o(chan_en_o), .sleep_o(sleep_o), .irq_o(irq_o));
   adcsf_core_model #(.LAT(LAT)) core (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .start_i(start_o), .ch_i(cch), .d_i(cd), .eoc_o(eoc_i), .chan_o(conv_chan_i),
      .busy_o(conv_busy_i));
   initial
      forever #4 sys_clk_i = ~sys_clk_i;
   // one bus cycle per call; a read notes its expected answer and mask
   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v,
      input logic [31:0] m);
      @(posedge sys_clk_i);
      bus_i <= '{wr: w, rd: r, addr: a, wdata: (w ? v : 32'h0)};
      if (r)
      begin
         eq.push_back(v);
         mq.push_back(m);
      end
   endtask
   task automatic n();
      op(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      op(1'b1, 1'b0, a, v, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      op(1'b0, 1'b1, a, e, m);
   endtask
   task automatic s(input logic [31:0] e);
      rd(OFF_STATUS, e, 32'h3FFFF);
   endtask
   // start a conversion; the second call after it lands on the end pulse
   task automatic conv(input int ch);
      d = RES_W'($random(seed));
      cch <= CH_W'(ch);
      cd <= d;
      wr(OFF_CTRL, 32'h2);
      repeat (LAT - 1) n();
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // answer watcher: each read answer is judged against the oldest note
   always @(posedge sys_clk_i)
   begin
      if (rd_d)
      begin
         `CHK(rdata_o & mq[0], eq[0] & mq[0])
         void'(eq.pop_front());
         void'(mq.pop_front());
      end
      rd_d <= bus_i.rd;
   end
   // hang guard
   initial
   begin
      repeat (5000) @(posedge sys_clk_i);
      bad_count++;
      report_and_stop();
   end
   initial
   begin
      repeat (12) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      wr(OFF_CHEN, 32'hFF);
      wr(OFF_IRQ_MASK, 32'hF);
      // sleep written first, then a start: it must wait for the end pulse
      wr(OFF_MODE, 32'h20);
      n();
      #1 `CHK(sleep_o, 1'b0)
      conv(2);
      n();
      n();
      n();
      #1 `CHK(sleep_o, 1'b1)
      s(32'h10004);
      rd(OFF_CHDATA0 + 8'h08, {22'h0, d}, 32'h3FF);
      s(32'h10000);
      conv(5);
      n();
      s(32'h10000);
      s(32'h30020);
      rd(OFF_LAST, {17'h0, 3'h5, 2'h0, d}, 32'h73FF);
      s(32'h0);
      // data-ready up, then a last-data read meets the end of a disabled channel
      conv(6);
      n();
      n();
      conv(4);
      wr(OFF_CHDIS, 32'h10);
      rd(OFF_LAST, 32'h0, 32'h0);
      s(32'h0);
      wr(OFF_CHEN, 32'h10);
      conv(1);
      n();
      n();
      conv(1);
      n();
      wr(OFF_CHDIS, 32'h40);
      s(32'h30202);
      rd(OFF_LAST, {17'h0, 3'h1, 2'h0, d}, 32'h73FF);
      conv(3);
      n();
      wr(OFF_CHDIS, 32'h01);
      s(32'h10008);
      rd(OFF_LAST, 32'h0, 32'h0);
      conv(2);
      n();
      n();
      conv(5);
      n();
      n();
      s(32'h30024);
      conv(2);
      n();
      rd(OFF_CHDATA0 + 8'h1C, 32'h0, 32'h0);
      s(32'h30424);
      conv(2);
      n();
      n();
      rd(OFF_CHDATA0 + 8'h08, {22'h0, d}, 32'h3FF);
      conv(2);
      n();
      s(32'h30420);
      s(32'h30024);
      conv(1);
      n();
      n();
      rd(OFF_LAST, 32'h0, 32'h0);
      conv(3);
      n();
      s(32'h20000);
      s(32'h10008);
      conv(4);
      n();
      rd(OFF_CHDATA0 + 8'h1C, 32'h0, 32'h0);
      s(32'h30018);
      // interrupt: raised, cleared, then masked while events still stick
      #1 `CHK(irq_o, 1'b1)
      wr(OFF_IRQ_ST, 32'hF);
      n();
      #1 `CHK(irq_o, 1'b0)
      wr(OFF_IRQ_MASK, 32'h0);
      conv(1);
      n();
      n();
      rd(OFF_IRQ_ST, 32'h1, 32'h1);
      rd(8'hFC, 32'h0, 32'hFFFFFFFF);
      rd(OFF_CHSR, 32'hBE, 32'hFFFFFFFF);
      rd(OFF_MODE, 32'h20, 32'hFFFFFFFF);
      n();
      #1 `CHK(irq_o, 1'b0)
      `CHK(chan_en_o, 8'hBE)
      repeat (3) n();
      report_and_stop();
   end
endmodule
